// >>> inc/dct_pkg.sv
// Shared constants, types and helpers for both ends of the cycle-timed link.
// Assumes both ends run on one clock, core_clk, which is also the memory clock.
package dct_pkg;
  // Clock period and printed nanosecond figures
  localparam int unsigned TCK_PS     = 25000;
  localparam int unsigned TRP_NS     = 15;
  localparam int unsigned TRCD_NS    = 15;
  // Figures already given in whole clock cycles
  localparam int unsigned TWTR_NCK   = 2;
  localparam int unsigned TCKE_NCK   = 3;
  localparam int unsigned TXP_NCK    = 2;
  localparam int unsigned WR_NCK     = 2;
  localparam int unsigned BURST_LEN  = 2;
  localparam int unsigned READ_LAT   = 2;
  // Widths
  localparam int unsigned BANK_W     = 2;
  localparam int unsigned ROW_W      = 4;
  localparam int unsigned COL_W      = 4;
  localparam int unsigned ADDR_W     = 14;
  localparam int unsigned DQ_W       = 16;
  localparam int unsigned CNT_W      = 4;
  localparam int unsigned LOC_W      = BANK_W + ROW_W + COL_W;
  localparam int unsigned BANKS      = 1 << BANK_W;
  // Strobe select bit of the extended mode word
  localparam int unsigned STROBE_BIT = 10;

  // Nanoseconds to clock cycles, rounded up, never below one
  function automatic int unsigned ns_to_nck(input int unsigned ns);
    int unsigned n;
    n = (ns * 1000 + TCK_PS - 1) / TCK_PS;
    return (n == 0) ? 1 : n;
  endfunction

  localparam int unsigned TRP_NCK  = ns_to_nck(TRP_NS);
  localparam int unsigned TRCD_NCK = ns_to_nck(TRCD_NS);
  localparam int unsigned TDAL_NCK = WR_NCK + TRP_NCK;
  localparam int unsigned TRDA_NCK = BURST_LEN + TRP_NCK;

  // Counter load values: a timing load of N-1 at the event edge frees edge N; BURST_LD and RDLAT_LD load full counts
  localparam logic [CNT_W-1:0] TWTR_LD  = CNT_W'(TWTR_NCK - 1);
  localparam logic [CNT_W-1:0] TCKE_LD  = CNT_W'(TCKE_NCK - 1);
  localparam logic [CNT_W-1:0] TXP_LD   = CNT_W'(TXP_NCK - 1);
  localparam logic [CNT_W-1:0] TRCD_LD  = CNT_W'(TRCD_NCK - 1);
  localparam logic [CNT_W-1:0] TDAL_LD  = CNT_W'(TDAL_NCK - 1);
  localparam logic [CNT_W-1:0] TRDA_LD  = CNT_W'(TRDA_NCK - 1);
  localparam logic [CNT_W-1:0] BURST_LD = CNT_W'(BURST_LEN);
  localparam logic [CNT_W-1:0] RDLAT_LD = CNT_W'(READ_LAT + BURST_LEN);

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_WRA = 3'h2,
    CMD_RDA = 3'h3,
    CMD_EMR = 3'h4
  } dct_cmd_t;

  // Count down to zero and stay there
  function automatic logic [CNT_W-1:0] dct_dec(input logic [CNT_W-1:0] c);
    return (c == '0) ? c : c - 4'h1;
  endfunction

  // Flat storage index of one word
  function automatic logic [LOC_W-1:0] dct_loc(
    input logic [BANK_W-1:0] b,
    input logic [ROW_W-1:0]  r,
    input logic [COL_W-1:0]  c
  );
    return {b, r, c};
  endfunction
endpackage

// >>> inc/dct_link_if.sv
// Link between the memory controller end and the memory device end.
// Assumes both ends share core_clk; shared data and strobe wires resolve here.
`timescale 1ns/1ps
interface dct_link_if (
  input wire logic core_clk
);
  import dct_pkg::*;
  logic                cke;
  dct_cmd_t            cmd;
  logic [BANK_W-1:0]   bank;
  logic [ADDR_W-1:0]   addr;
  logic [DQ_W-1:0]     dq_c_o;
  logic                dq_c_oe;
  logic [DQ_W-1:0]     dq_d_o;
  logic                dq_d_oe;
  logic                dqs_t_o;
  logic                dqs_t_oe;
  logic                dqs_c_o;
  logic                dqs_c_oe;
  logic                rd_bad;
  logic [DQ_W-1:0]     dq;
  logic                dqs_t;
  logic                dqs_c;

  // Undriven true strobe rests low and complement rests high, like a terminated line
  assign dq    = dq_c_oe ? dq_c_o : (dq_d_oe ? dq_d_o : '0);
  assign dqs_t = dqs_t_oe ? dqs_t_o : 1'b0;
  assign dqs_c = dqs_c_oe ? dqs_c_o : 1'b1;

  modport ctl (
    output cke, cmd, bank, addr, dq_c_o, dq_c_oe,
    output dqs_t_o, dqs_t_oe, dqs_c_o, dqs_c_oe,
    input  dq, rd_bad
  );
  modport mem (
    input  cke, cmd, bank, addr, dq, dqs_t, dqs_c,
    output dq_d_o, dq_d_oe, rd_bad
  );
endinterface

// >>> core/dct_mem_end.sv
// Memory device end: clock-enable registration, strobe select, storage.
// Assumes the controller drives commands on core_clk and keeps its spacing.
`timescale 1ns/1ps
module dct_mem_end (
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  dct_link_if.mem                    lk,
  output logic                       strobe_single,
  output logic                       powered_down,
  output logic                       timing_err
);
  import dct_pkg::*;

  if (TDAL_NCK >= (1 << CNT_W) || TRDA_NCK >= (1 << CNT_W)) begin : g_chk
    $error("dct_mem_end: counter width too small for timing loads");
  end

  typedef struct packed {
    logic [TCKE_NCK-1:0]            cke_hist;
    logic                           cke_eff;
    logic                           single;
    logic [CNT_W-1:0]               cke_hold;
    logic [CNT_W-1:0]               xp;
    logic [CNT_W-1:0]               wtr;
    logic [BANKS-1:0][CNT_W-1:0]    bank_busy;
    logic [BANKS-1:0][ROW_W-1:0]    open_row;
    logic [CNT_W-1:0]               wr_left;
    logic [CNT_W-1:0]               rd_left;
    logic [LOC_W-1:0]               loc;
    logic [DQ_W-1:0]                dq;
    logic                           dq_oe;
    logic                           bad;
    logic                           err;
  } dct_mstate_t;

  dct_mstate_t               cur;
  dct_mstate_t               nxt;
  logic [DQ_W-1:0]           mem [0:(1 << LOC_W)-1];
  logic                      corrupt [0:(1 << LOC_W)-1];
  logic                      wr_en;
  logic                      wr_ok;
  logic [LOC_W-1:0]          wr_loc;
  logic [LOC_W-1:0]          rd_loc;

  // Beat index grows as the remaining count falls
  assign wr_loc = cur.loc + LOC_W'(BURST_LEN - cur.wr_left);
  assign wr_en  = (cur.wr_left != '0);
  // Strobe form picked by the mode bit: differential pair or lone true
  assign wr_ok  = cur.single ? lk.dqs_t : (lk.dqs_t && !lk.dqs_c);

  always_comb begin
    nxt          = cur;
    nxt.err      = 1'b0;
    nxt.cke_hold = dct_dec(cur.cke_hold);
    nxt.xp       = dct_dec(cur.xp);
    nxt.wtr      = dct_dec(cur.wtr);
    for (int b = 0; b < BANKS; b++) begin
      nxt.bank_busy[b] = dct_dec(cur.bank_busy[b]);
    end
    // Clock enable counts only after three equal samples in a row
    nxt.cke_hist = {cur.cke_hist[TCKE_NCK-2:0], lk.cke};
    if (lk.cke != cur.cke_hist[0]) begin
      if (cur.cke_hold != '0) nxt.err = 1'b1;
      nxt.cke_hold = TCKE_LD;
    end
    if (&nxt.cke_hist && !cur.cke_eff) begin
      nxt.cke_eff = 1'b1;
      nxt.xp      = TXP_LD;
    end else if (~|nxt.cke_hist) begin
      nxt.cke_eff = 1'b0;
    end
    // Write beats captured one per edge; a bad strobe taints the word
    if (wr_en) begin
      nxt.wr_left = cur.wr_left - 4'h1;
      if (cur.wr_left == 4'h1) begin
        nxt.wtr = TWTR_LD;
        nxt.bank_busy[cur.loc[LOC_W-1 -: BANK_W]] = TDAL_LD;
      end
    end
    // Commands are judged by counted edges only, never by elapsed time
    if (cur.cke_eff && lk.cmd != CMD_NOP) begin
      if (cur.xp != '0) nxt.err = 1'b1;
      case (lk.cmd)
        CMD_ACT: begin
          if (cur.bank_busy[lk.bank] != '0) nxt.err = 1'b1;
          nxt.open_row[lk.bank] = lk.addr[ROW_W-1:0];
        end
        CMD_WRA: begin
          nxt.loc     = dct_loc(lk.bank, cur.open_row[lk.bank],
                                lk.addr[COL_W-1:0]);
          nxt.wr_left = BURST_LD;
        end
        CMD_RDA: begin
          if (cur.wtr != '0) nxt.err = 1'b1;
          nxt.loc     = dct_loc(lk.bank, cur.open_row[lk.bank],
                                lk.addr[COL_W-1:0]);
          nxt.rd_left = RDLAT_LD;
          nxt.bank_busy[lk.bank] = TRDA_LD;
        end
        CMD_EMR: nxt.single = lk.addr[STROBE_BIT];
        default: nxt.err = 1'b1;
      endcase
    end
    // Read beats leave after the latency, one per edge
    nxt.dq_oe = 1'b0;
    nxt.bad   = 1'b0;
    if (cur.rd_left != '0) begin
      nxt.rd_left = cur.rd_left - 4'h1;
      if (nxt.rd_left != '0 && nxt.rd_left <= BURST_LD) begin
        nxt.dq_oe = 1'b1;
        nxt.dq    = mem[rd_loc];
        nxt.bad   = corrupt[rd_loc];
      end
    end
  end

  // Beat index taken from the current count, so no path loops through nxt
  assign rd_loc = cur.loc + LOC_W'(BURST_LEN + 1 - 32'(cur.rd_left));

  // State register; power-up leaves the clock enabled and the strobe paired
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cur          <= '0;
      cur.cke_hist <= '1;
      cur.cke_eff  <= 1'b1;
    end else begin
      cur <= nxt;
    end
  end

  // Storage; no reset, contents are undefined until written
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_loc]     <= lk.dq;
      corrupt[wr_loc] <= !wr_ok;
    end
  end

  assign lk.dq_d_o      = cur.dq;
  assign lk.dq_d_oe     = cur.dq_oe;
  assign lk.rd_bad      = cur.bad;
  assign strobe_single  = cur.single;
  assign powered_down   = !cur.cke_eff;
  assign timing_err     = cur.err;
endmodule

// >>> core/dct_ctl_end.sv
// Memory controller end: turns word requests into spaced link commands.
// Assumes the device end samples the link on the same core_clk edges.
`timescale 1ns/1ps
module dct_ctl_end (
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  dct_link_if.ctl                          lk,
  input  wire logic                        req_valid,
  output logic                             req_ready,
  input  wire logic                        req_write,
  input  wire logic [dct_pkg::BANK_W-1:0]  req_bank,
  input  wire logic [dct_pkg::ROW_W-1:0]   req_row,
  input  wire logic [dct_pkg::COL_W-1:0]   req_col,
  input  wire logic [2*dct_pkg::DQ_W-1:0]  req_wdata,
  output logic                             rsp_valid,
  output logic [2*dct_pkg::DQ_W-1:0]       rsp_data,
  output logic                             rsp_err,
  input  wire logic                        pd_req,
  input  wire logic                        strobe_single,
  output logic                             powered_down
);
  import dct_pkg::*;

  if (BURST_LEN != 2 || TDAL_NCK >= (1 << CNT_W)
      || TCKE_NCK + TXP_NCK >= (1 << CNT_W)) begin : g_chk
    $error("dct_ctl_end: burst must be 2 and loads must fit counters");
  end

  localparam logic [CNT_W-1:0] XP_LD = CNT_W'(TCKE_NCK + TXP_NCK - 1);
  localparam logic [CNT_W-1:0] RD_LD = CNT_W'(READ_LAT + BURST_LEN + 1);

  typedef enum logic [2:0] {
    ST_INIT = 3'h0,
    ST_IDLE = 3'h1,
    ST_ACT  = 3'h2,
    ST_WR   = 3'h3,
    ST_RD   = 3'h4,
    ST_PD   = 3'h5
  } dct_cst_t;

  typedef struct packed {
    dct_cst_t                       st;
    logic                           cke;
    dct_cmd_t                       cmd;
    logic [BANK_W-1:0]              bank;
    logic [ADDR_W-1:0]              addr;
    logic [DQ_W-1:0]                dq;
    logic                           dq_oe;
    logic                           single;
    logic [CNT_W-1:0]               beat;
    logic [CNT_W-1:0]               rdc;
    logic [CNT_W-1:0]               rcd;
    logic [CNT_W-1:0]               wtr;
    logic [CNT_W-1:0]               cke_hold;
    logic [CNT_W-1:0]               xp;
    logic [BANKS-1:0][CNT_W-1:0]    bank_wait;
    logic                           q_write;
    logic [BANK_W-1:0]              q_bank;
    logic [ROW_W-1:0]               q_row;
    logic [COL_W-1:0]               q_col;
    logic [2*DQ_W-1:0]              q_data;
    logic                           q_bad;
    logic                           rsp_valid;
    logic                           rsp_err;
  } dct_cstate_t;

  dct_cstate_t               cur;
  dct_cstate_t               nxt;
  logic                      needs_rewrite [0:(1 << LOC_W)-1];
  logic                      req_take;
  logic                      req_marked;
  logic                      mark_set;
  logic                      mark_clr;
  logic [LOC_W-1:0]          q_loc;

  assign q_loc      = dct_loc(cur.q_bank, cur.q_row, cur.q_col);
  assign req_marked = needs_rewrite[dct_loc(req_bank, req_row, req_col)];

  // A marked read is answered at once, so it needs no bank slot
  assign req_ready = (cur.st == ST_IDLE) && !pd_req && (cur.xp == '0)
                     && ((cur.bank_wait[req_bank] == '0)
                         || (!req_write && req_marked));
  assign req_take  = req_valid && req_ready;

  // Mark words that came back tainted; a fresh write clears the mark
  assign mark_set = (cur.st == ST_RD) && (cur.rdc != '0)
                    && (cur.rdc <= BURST_LD) && lk.rd_bad;
  assign mark_clr = (cur.st == ST_WR) && (cur.beat == BURST_LD);

  always_comb begin
    nxt           = cur;
    nxt.cmd       = CMD_NOP;
    nxt.dq_oe     = 1'b0;
    nxt.rsp_valid = 1'b0;
    nxt.rcd       = dct_dec(cur.rcd);
    nxt.wtr       = dct_dec(cur.wtr);
    nxt.cke_hold  = dct_dec(cur.cke_hold);
    nxt.xp        = dct_dec(cur.xp);
    for (int b = 0; b < BANKS; b++) begin
      nxt.bank_wait[b] = dct_dec(cur.bank_wait[b]);
    end
    case (cur.st)
      // Mode word once after reset; strap caught here, not in reset
      ST_INIT: begin
        nxt.cmd                   = CMD_EMR;
        nxt.addr                  = '0;
        nxt.addr[STROBE_BIT]      = strobe_single;
        nxt.single                = strobe_single;
        nxt.st                    = ST_IDLE;
      end
      ST_IDLE: begin
        if (req_take) begin
          nxt.q_write = req_write;
          nxt.q_bank  = req_bank;
          nxt.q_row   = req_row;
          nxt.q_col   = req_col;
          nxt.q_data  = req_wdata;
          nxt.q_bad   = 1'b0;
          if (!req_write && req_marked) begin
            nxt.rsp_valid = 1'b1;
            nxt.rsp_err   = 1'b1;
          end else begin
            nxt.cmd  = CMD_ACT;
            nxt.bank = req_bank;
            nxt.addr = ADDR_W'(req_row);
            nxt.rcd  = TRCD_LD;
            nxt.st   = ST_ACT;
          end
        end else if (pd_req && cur.cke_hold == '0) begin
          nxt.cke      = 1'b0;
          nxt.cke_hold = TCKE_LD;
          nxt.st       = ST_PD;
        end
      end
      // Column command once row delay is spent; a read also waits out the write-to-read gap
      ST_ACT: begin
        if (cur.rcd == '0) begin
          if (cur.q_write) begin
            nxt.cmd  = CMD_WRA;
            nxt.addr = ADDR_W'(cur.q_col);
            nxt.beat = BURST_LD;
            nxt.st   = ST_WR;
          end else if (cur.wtr == '0) begin
            nxt.cmd  = CMD_RDA;
            nxt.addr = ADDR_W'(cur.q_col);
            nxt.rdc  = RD_LD;
            nxt.bank_wait[cur.q_bank] = TRDA_LD;
            nxt.st   = ST_RD;
          end
        end
      end
      // Low half first, then high half
      ST_WR: begin
        if (cur.beat != '0) begin
          nxt.dq_oe = 1'b1;
          nxt.dq    = (cur.beat == BURST_LD) ? cur.q_data[DQ_W-1:0]
                                             : cur.q_data[2*DQ_W-1:DQ_W];
          nxt.beat  = cur.beat - 4'h1;
        end else begin
          nxt.wtr                   = TWTR_LD;
          nxt.bank_wait[cur.q_bank] = TDAL_LD;
          nxt.rsp_valid             = 1'b1;
          nxt.rsp_err               = 1'b0;
          nxt.st                    = ST_IDLE;
        end
      end
      // Beats land at fixed counted edges after the command
      ST_RD: begin
        nxt.rdc = cur.rdc - 4'h1;
        if (cur.rdc == BURST_LD) begin
          nxt.q_data[DQ_W-1:0] = lk.dq;
          nxt.q_bad            = lk.rd_bad;
        end else if (cur.rdc == 4'h1) begin
          nxt.q_data[2*DQ_W-1:DQ_W] = lk.dq;
          nxt.rsp_valid             = 1'b1;
          nxt.rsp_err               = cur.q_bad || lk.rd_bad;
          nxt.st                    = ST_IDLE;
        end
      end
      // Exit once the entry level has been held long enough
      ST_PD: begin
        if (!pd_req && cur.cke_hold == '0) begin
          nxt.cke      = 1'b1;
          nxt.cke_hold = TCKE_LD;
          nxt.xp       = XP_LD;
          nxt.st       = ST_IDLE;
        end
      end
      default: nxt.st = ST_INIT;
    endcase
  end

  // State register; clock enable stays high through reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cur     <= '0;
      cur.st  <= ST_INIT;
      cur.cke <= 1'b1;
    end else begin
      cur <= nxt;
    end
  end

  // Rewrite marks; set wins if both land in one cycle
  always_ff @(posedge core_clk) begin
    if (mark_set) begin
      needs_rewrite[q_loc] <= 1'b1;
    end else if (mark_clr) begin
      needs_rewrite[q_loc] <= 1'b0;
    end
  end

  // Pair drives both halves; single mode leaves the complement idle
  assign lk.cke      = cur.cke;
  assign lk.cmd      = cur.cmd;
  assign lk.bank     = cur.bank;
  assign lk.addr     = cur.addr;
  assign lk.dq_c_o   = cur.dq;
  assign lk.dq_c_oe  = cur.dq_oe;
  assign lk.dqs_t_o  = cur.dq_oe;
  assign lk.dqs_t_oe = cur.dq_oe;
  assign lk.dqs_c_o  = 1'b0;
  assign lk.dqs_c_oe = cur.dq_oe && !cur.single;
  assign rsp_valid   = cur.rsp_valid;
  assign rsp_data    = cur.q_data;
  assign rsp_err     = cur.rsp_err;
  assign powered_down = (cur.st == ST_PD);
endmodule

// >>> verification/dct_link_monitor.sv
// Checker for the link that joins the controller end and memory end.
// Assumes it sits beside the interface and gets its signals by name.
`timescale 1ns/1ps
module dct_link_monitor (
  input wire logic                        core_clk,
  input wire logic                        reset,
  input wire logic                        cke,
  input wire dct_pkg::dct_cmd_t           cmd,
  input wire logic [dct_pkg::BANK_W-1:0]  bank,
  input wire logic                        dq_c_oe,
  input wire logic                        dqs_t,
  input wire logic                        dqs_c,
  input wire logic                        dqs_c_oe,
  input wire logic                        dq_d_oe,
  input wire logic                        rd_bad
);
  import dct_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  // Write burst: two driven beats, then the data bus is let go
  sequence s_wr_burst;
    dq_c_oe ##1 dq_c_oe ##1 !dq_c_oe;
  endsequence
  // Read burst lands three samples after the read command
  sequence s_rd_burst;
    ##3 dq_d_oe ##1 dq_d_oe ##1 !dq_d_oe;
  endsequence
  // Exit counts once the high level is seen on three edges
  sequence s_exit;
    $rose(cke) ##1 cke ##1 cke;
  endsequence

  property p_wtr;
    (dq_c_oe || $fell(dq_c_oe)) |-> cmd != CMD_RDA;
  endproperty
  a_wtr: assert property (p_wtr)
    else $error("read command too close to write burst");
  property p_cke_reg;
    $changed(cke) |=> $stable(cke) [*2];
  endproperty
  a_cke_reg: assert property (p_cke_reg)
    else $error("clock enable not held for three samples");
  property p_cke_low;
    $fell(cke) |-> (!cke) [*3];
  endproperty
  a_cke_low: assert property (p_cke_low)
    else $error("clock enable raised too early");
  property p_no_corrupt;
    dq_c_oe |-> dqs_t && (!dqs_c_oe || !dqs_c);
  endproperty
  a_no_corrupt: assert property (p_no_corrupt)
    else $error("write beat sent without a valid strobe");
  property p_wr_burst;
    cmd == CMD_WRA |=> s_wr_burst;
  endproperty
  a_wr_burst: assert property (p_wr_burst)
    else $error("write burst length or timing wrong");
  // Bank holds from its activate, so two samples back is the written bank;
  // another bank may be opened on the next sample
  property p_tdal;
    $fell(dq_c_oe) |-> cmd != CMD_ACT
      ##1 !(cmd == CMD_ACT && bank == $past(bank, 2));
  endproperty
  a_tdal: assert property (p_tdal)
    else $error("activate inside write recovery");
  property p_exit;
    s_exit |-> cmd == CMD_NOP ##1 cmd == CMD_NOP;
  endproperty
  a_exit: assert property (p_exit)
    else $error("command too soon after power-down exit");
  property p_rd_burst;
    cmd == CMD_RDA |-> s_rd_burst;
  endproperty
  a_rd_burst: assert property (p_rd_burst)
    else $error("read data beats misplaced");
  property p_rda_busy;
    cmd == CMD_RDA |=> (cmd != CMD_ACT) [*2];
  endproperty
  a_rda_busy: assert property (p_rda_busy)
    else $error("activate while bank still busy");
  property p_rd_clean;
    dq_d_oe |-> !rd_bad;
  endproperty
  a_rd_clean: assert property (p_rd_clean)
    else $error("corrupt beat on clean link");
endmodule

// >>> verification/ddr2_cycle_timing_rules_tb_top.sv
// Bench: controller and memory ends joined, plus a second faulty link.
// Assumes dct_pkg, the interface and both design ends are compiled first.
`timescale 1ns/1ps
module ddr2_cycle_timing_rules_tb_top;
  import dct_pkg::*;
  logic        core_clk  = 1'b0;
  logic        reset     = 1'b1;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic [1:0]  req_bank  = 2'h0;
  logic [3:0]  req_row   = 4'h0;
  logic [3:0]  req_col   = 4'h0;
  logic [31:0] req_wdata = 32'h0;
  logic        pd_req    = 1'b0;
  logic        mode      = 1'b0;
  logic        req_ready, rsp_valid, rsp_err, pd_ctl;
  logic [31:0] rsp_data;
  logic        ss_mem, pd_mem, terr, ss2, pd2, terr2;
  int          num_errors = 0;
  int          checked    = 0;
  int          cycles     = 0;
  logic [15:0] mdl [int];  // One data beat per storage location
  int          locs [$];

  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;

  dct_link_if lk (.core_clk(core_clk));
  dct_link_if lk2 (.core_clk(core_clk));
  dct_ctl_end i_dct_ctl_end (
    .core_clk(core_clk), .reset(reset), .lk(lk), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_bank(req_bank),
    .req_row(req_row), .req_col(req_col), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err),
    .pd_req(pd_req), .strobe_single(mode), .powered_down(pd_ctl));
  dct_mem_end i_dct_mem_end (
    .core_clk(core_clk), .reset(reset), .lk(lk), .strobe_single(ss_mem),
    .powered_down(pd_mem), .timing_err(terr));
  // Second device end, fed by the bench so that rules can be broken
  dct_mem_end i_dct_mem_end_2 (
    .core_clk(core_clk), .reset(reset), .lk(lk2), .strobe_single(ss2),
    .powered_down(pd2), .timing_err(terr2));
  dct_link_monitor i_dct_link_monitor (
    .core_clk(core_clk), .reset(reset), .cke(lk.cke), .cmd(lk.cmd),
    .bank(lk.bank),
    .dq_c_oe(lk.dq_c_oe), .dqs_t(lk.dqs_t), .dqs_c(lk.dqs_c),
    .dqs_c_oe(lk.dqs_c_oe), .dq_d_oe(lk.dq_d_oe), .rd_bad(lk.rd_bad));

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One word request; holds valid until the edge that takes it
  task automatic xfer(input logic wr, input logic [9:0] loc,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_write <= wr;
    {req_bank, req_row, req_col} <= loc;
    req_wdata <= d;
    @(negedge core_clk);
    while (req_ready !== 1'b1 && n < 100) begin
      n++;
      @(negedge core_clk);
    end
    @(posedge core_clk);
    req_valid <= 1'b0;
    @(negedge core_clk);
    while (rsp_valid !== 1'b1 && n < 200) begin
      n++;
      @(negedge core_clk);
    end
    chk("rsp_valid", 1, rsp_valid);
    chk("rsp_err", 0, rsp_err);
    // A burst of two beats fills this location and the next one
    if (!wr) begin
      chk("rsp_data", {mdl[10'(loc + 1)], mdl[loc]}, rsp_data);
    end else begin
      mdl[loc]          = d[15:0];
      mdl[10'(loc + 1)] = d[31:16];
    end
  endtask

  // Bench drive of the faulty link's command bus
  task automatic drv(input dct_cmd_t c, input logic [13:0] a);
    @(posedge core_clk);
    lk2.cmd  <= c;
    lk2.addr <= a;
  endtask

  // Cycle ceiling; also any timing fault on the clean link counts
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      num_errors++;
      end_sim();
    end
    if (!reset && terr === 1'b1) begin
      num_errors++;
      $display("[ERR] timing_err expected 0 seen 1");
    end
  end

  // Main sequence: both strobe modes, traffic, power-down, faults
  initial begin
    logic [9:0]  w;
    logic [31:0] d;
    int          hits;
    void'($urandom(57361));
    lk2.cke = 1'b1;
    lk2.cmd = CMD_NOP;
    lk2.bank = 2'h0;
    lk2.addr = 14'h0;
    lk2.dq_c_o = 16'h0;
    lk2.dq_c_oe = 1'b0;
    lk2.dqs_t_o = 1'b0;
    lk2.dqs_t_oe = 1'b0;
    lk2.dqs_c_o = 1'b1;
    lk2.dqs_c_oe = 1'b0;
    for (int m = 0; m < 2; m++) begin
      @(posedge core_clk);
      reset <= 1'b1;
      mode  <= m[0];
      repeat (12) @(posedge core_clk);
      reset <= 1'b0;
      repeat (4) @(negedge core_clk);
      chk("strobe_single", m, ss_mem);
      repeat (10) begin
        w = 10'($urandom());
        d = $urandom();
        xfer(1'b1, w, d);
        locs.push_back(w);
        xfer(1'b0, w, 32'h0);
        xfer(1'b0, 10'(locs[$urandom_range(locs.size() - 1)]), 32'h0);
      end
      @(posedge core_clk);
      pd_req <= 1'b1;
      for (int i = 0; i < 20 && pd_mem !== 1'b1; i++) @(negedge core_clk);
      chk("pd_ctl", 1, pd_ctl);
      chk("pd_mem", 1, pd_mem);
      @(posedge core_clk);
      pd_req <= 1'b0;
      xfer(1'b0, w, 32'h0);
      chk("pd_mem", 0, pd_mem);
    end
    // Write beats with no strobe leave the word marked corrupt
    drv(CMD_ACT, 14'h0);
    drv(CMD_WRA, 14'h5);
    @(posedge core_clk);
    lk2.cmd <= CMD_NOP;
    lk2.dq_c_oe <= 1'b1;
    lk2.dq_c_o <= 16'h1234;
    @(posedge core_clk);
    lk2.dq_c_o <= 16'h4321;
    @(posedge core_clk);
    lk2.dq_c_oe <= 1'b0;
    repeat (3) @(posedge core_clk);
    drv(CMD_RDA, 14'h5);
    drv(CMD_NOP, 14'h0);
    hits = 0;
    repeat (6) begin
      @(negedge core_clk);
      if (lk2.rd_bad === 1'b1) hits++;
    end
    chk("rd_bad_beats", 2, hits);
    // Clock enable bounced back after one cycle must be flagged
    hits = 0;
    @(posedge core_clk);
    lk2.cke <= 1'b0;
    @(posedge core_clk);
    lk2.cke <= 1'b1;
    repeat (6) begin
      @(negedge core_clk);
      if (terr2 === 1'b1) hits++;
    end
    chk("timing_err", 1, hits != 0);
    end_sim();
  end
endmodule
